/* File: design/mdso_params.svh */
`ifndef MDSO_PARAMS_SVH
`define MDSO_PARAMS_SVH
// Register offsets (word index on the plain register port)
`define MDSO_OFS_TEMP_LIM      8'h00
`define MDSO_OFS_OVLD_TIME     8'h01
`define MDSO_OFS_SPEED_LIM     8'h02
`define MDSO_OFS_OVER_V        8'h03
`define MDSO_OFS_UNDER_V       8'h04
`define MDSO_OFS_DEV_LIM       8'h05
`define MDSO_OFS_HOME_MODE     8'h06
`define MDSO_OFS_MOVE_MIN      8'h07
`define MDSO_OFS_END_RANGE     8'h08
`define MDSO_OFS_END_OFFSET    8'h09
`define MDSO_OFS_STATUS        8'h0A
`define MDSO_OFS_ZONE_BASE     8'h10
// Reset values
`define MDSO_RST_TEMP_LIM      16'h0055
`define MDSO_RST_OVLD_TIME     16'h0032
`define MDSO_RST_SPEED_LIM     16'h1194
`define MDSO_RST_OVER_V_AC     16'h01B3
`define MDSO_RST_OVER_V_DC     16'h0276
`define MDSO_RST_UNDER_V_AC    16'h0078
`define MDSO_RST_UNDER_V_DC    16'h00B4
`define MDSO_RST_DEV_LIM       16'h012C
`define MDSO_RST_END_RANGE     16'h0012
`define MDSO_RST_HOME_MODE     1'b0
`define MDSO_RST_MOVE_MIN      8'h00
`define MDSO_RST_END_OFFSET    16'h0000
`define MDSO_RST_ZONE          24'h000000
// Timing
`define MDSO_CLK_HZ            100000000
`define MDSO_MS_CYCLES         (`MDSO_CLK_HZ / 1000)
`define MDSO_TENTH_S_CYCLES    (`MDSO_CLK_HZ / 10)
`endif

/* File: design/mdso_pkg.sv */
package mdso_pkg;
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] speed;
		logic [15:0] volt;
		logic [15:0] deviation;
		logic        overload;
	} mdso_meas_t;
	typedef struct packed {
		logic main_power;
		logic start_any;
		logic free_run;
		logic stop;
		logic cur_on_assigned;
		logic cur_on;
		logic alarm;
		logic busy_tool;
	} mdso_ready_in_t;
	typedef struct packed {
		logic signed [23:0] cmd_pos;
		logic signed [23:0] act_pos;
		logic               origin_set;
		logic               operating;
		logic               torque_over;
	} mdso_motion_t;
	typedef enum logic [1:0] {MV_IDLE, MV_RUN, MV_HOLD} mdso_move_st_t;
endpackage : mdso_pkg

/* File: design/mdso_status.sv */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "mdso_params.svh"
module mdso_status #(
	parameter bit          DC_INPUT     = 1'b0,
	parameter int unsigned MS_CYC       = `MDSO_MS_CYCLES,
	parameter int unsigned TENTH_S_CYC  = `MDSO_TENTH_S_CYCLES
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// Register port
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata,
	// Measurements and state from the drive (same clock)
	input  wire mdso_pkg::mdso_meas_t     meas,
	input  wire mdso_pkg::mdso_ready_in_t rdy_in,
	input  wire mdso_pkg::mdso_motion_t   motion,
	// Status outputs
	output logic                         warning_output,
	output logic                         ready_output,
	output logic                         home_output,
	output logic                         moving_output,
	output logic                         complete_output,
	output logic                         torque_limit_output,
	output logic                         zone_one_output,
	output logic                         zone_two_output,
	output logic                         zone_three_output
);
	import mdso_pkg::*;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] OVER_V_RST  =
		DC_INPUT ? `MDSO_RST_OVER_V_DC : `MDSO_RST_OVER_V_AC;
	localparam logic [15:0] UNDER_V_RST =
		DC_INPUT ? `MDSO_RST_UNDER_V_DC : `MDSO_RST_UNDER_V_AC;

	logic        [15:0] temp_lim;
	logic        [15:0] ovld_time;
	logic        [15:0] speed_lim;
	logic        [15:0] over_v;
	logic        [15:0] under_v;
	logic        [15:0] dev_lim;
	logic               home_mode;
	logic        [7:0]  move_min;
	logic        [15:0] end_range;
	logic signed [15:0] end_offset;
	logic signed [23:0] zone_pos [3];
	logic signed [23:0] zone_neg [3];

	// Inside test for one zone
	function automatic logic in_zone(input logic signed [23:0] p,
		input logic signed [23:0] hi, input logic signed [23:0] lo);
		if (hi < lo)
			return (p <= hi) || (p >= lo);
		else if (hi == lo)
			return p == hi;
		else
			return (p >= lo) && (p <= hi);
	endfunction : in_zone

	// Word index of one zone boundary; positive even, negative odd
	function automatic logic [7:0] zone_ofs(input int idx,
		input logic neg);
		return `MDSO_OFS_ZONE_BASE + 8'(2 * idx) + {7'h00, neg};
	endfunction : zone_ofs

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			temp_lim   <= `MDSO_RST_TEMP_LIM;
			ovld_time  <= `MDSO_RST_OVLD_TIME;
			speed_lim  <= `MDSO_RST_SPEED_LIM;
			over_v     <= OVER_V_RST;
			under_v    <= UNDER_V_RST;
			dev_lim    <= `MDSO_RST_DEV_LIM;
			home_mode  <= `MDSO_RST_HOME_MODE;
			move_min   <= `MDSO_RST_MOVE_MIN;
			end_range  <= `MDSO_RST_END_RANGE;
			end_offset <= `MDSO_RST_END_OFFSET;
			for (int i = 0; i < 3; i++) begin
				zone_pos[i] <= `MDSO_RST_ZONE;
				zone_neg[i] <= `MDSO_RST_ZONE;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`MDSO_OFS_TEMP_LIM:   temp_lim   <= reg_wdata[15:0];
				`MDSO_OFS_OVLD_TIME:  ovld_time  <= reg_wdata[15:0];
				`MDSO_OFS_SPEED_LIM:  speed_lim  <= reg_wdata[15:0];
				`MDSO_OFS_OVER_V:     over_v     <= reg_wdata[15:0];
				`MDSO_OFS_UNDER_V:    under_v    <= reg_wdata[15:0];
				`MDSO_OFS_DEV_LIM:    dev_lim    <= reg_wdata[15:0];
				`MDSO_OFS_HOME_MODE:  home_mode  <= reg_wdata[0];
				`MDSO_OFS_MOVE_MIN:   move_min   <= reg_wdata[7:0];
				`MDSO_OFS_END_RANGE:  end_range  <= reg_wdata[15:0];
				`MDSO_OFS_END_OFFSET: end_offset <= reg_wdata[15:0];
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (reg_addr == zone_ofs(i, 1'b0))
							zone_pos[i] <= reg_wdata[23:0];
						if (reg_addr == zone_ofs(i, 1'b1))
							zone_neg[i] <= reg_wdata[23:0];
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= 32'h00000000;
			case (reg_addr)
				`MDSO_OFS_TEMP_LIM:   reg_rdata[15:0] <= temp_lim;
				`MDSO_OFS_OVLD_TIME:  reg_rdata[15:0] <= ovld_time;
				`MDSO_OFS_SPEED_LIM:  reg_rdata[15:0] <= speed_lim;
				`MDSO_OFS_OVER_V:     reg_rdata[15:0] <= over_v;
				`MDSO_OFS_UNDER_V:    reg_rdata[15:0] <= under_v;
				`MDSO_OFS_DEV_LIM:    reg_rdata[15:0] <= dev_lim;
				`MDSO_OFS_HOME_MODE:  reg_rdata[0]    <= home_mode;
				`MDSO_OFS_MOVE_MIN:   reg_rdata[7:0]  <= move_min;
				`MDSO_OFS_END_RANGE:  reg_rdata[15:0] <= end_range;
				`MDSO_OFS_END_OFFSET: reg_rdata[15:0] <= end_offset;
				`MDSO_OFS_STATUS: reg_rdata[8:0] <= {zone_three_output,
					zone_two_output, zone_one_output, torque_limit_output,
					complete_output, moving_output, home_output,
					ready_output, warning_output};
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (reg_addr == zone_ofs(i, 1'b0))
							reg_rdata[23:0] <= zone_pos[i];
						if (reg_addr == zone_ofs(i, 1'b1))
							reg_rdata[23:0] <= zone_neg[i];
					end
				end
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overload persistence timer, 0.1 s ticks
	logic [31:0] tenth_cnt;
	logic [15:0] ovld_ticks;
	logic        ovld_warn;
	always_ff @(posedge clk) begin
		if (!resetn || !meas.overload) begin
			tenth_cnt  <= 32'h00000000;
			ovld_ticks <= 16'h0000;
			ovld_warn  <= 1'b0;
		end else begin
			if (tenth_cnt == 32'(TENTH_S_CYC - 1)) begin
				tenth_cnt <= 32'h00000000;
				if (ovld_ticks != 16'hFFFF)
					ovld_ticks <= ovld_ticks + 16'h0001;
			end else begin
				tenth_cnt <= tenth_cnt + 32'h00000001;
			end
			ovld_warn <= ovld_ticks >= ovld_time;
		end
	end

	// Warning conditions are levels; output follows them
	always_ff @(posedge clk) begin
		if (!resetn)
			warning_output <= 1'b0;
		else
			warning_output <= (meas.temp >= temp_lim)
				|| ovld_warn
				|| (meas.speed > speed_lim)
				|| (meas.volt > over_v)
				|| (meas.volt < under_v)
				|| (rdy_in.cur_on && meas.deviation > dev_lim);
	end

	////////////////////////////////////////////////////////////////////////
	// Moving flag with a minimum on time in ms
	mdso_move_st_t mv_st;
	logic [31:0]   ms_cnt;
	logic [7:0]    ms_done;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mv_st   <= MV_IDLE;
			ms_cnt  <= 32'h00000000;
			ms_done <= 8'h00;
		end else begin
			case (mv_st)
				MV_IDLE: begin
					ms_cnt  <= 32'h00000000;
					ms_done <= 8'h00;
					if (motion.operating)
						mv_st <= MV_RUN;
				end
				MV_RUN, MV_HOLD: begin
					if (ms_cnt == 32'(MS_CYC - 1)) begin
						ms_cnt <= 32'h00000000;
						if (ms_done != 8'hFF)
							ms_done <= ms_done + 8'h01;
					end else begin
						ms_cnt <= ms_cnt + 32'h00000001;
					end
					if (motion.operating)
						mv_st <= MV_RUN;
					else if (ms_done >= move_min)
						mv_st <= MV_IDLE;
					else
						mv_st <= MV_HOLD;
				end
				default: mv_st <= MV_IDLE;
			endcase
		end
	end
	// Short pulses are stretched so a slow host still sees them
	assign moving_output = (mv_st != MV_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Ready, home, complete, torque, zones
	logic               home_latched;
	logic signed [23:0] settle_err;
	always_comb begin
		settle_err = motion.act_pos - motion.cmd_pos - 24'(end_offset);
		if (settle_err < 0)
			settle_err = -settle_err;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ready_output <= 1'b0;
		end else begin
			ready_output <= rdy_in.main_power && !rdy_in.start_any
				&& !rdy_in.free_run && !rdy_in.stop
				&& (!rdy_in.cur_on_assigned || rdy_in.cur_on)
				&& !rdy_in.alarm && !moving_output
				&& !rdy_in.busy_tool;
		end
	end

	// Origin state of the last cycle; resets low so an origin that
	// survives reset still counts as newly set
	logic origin_seen;
	always_ff @(posedge clk) begin
		if (!resetn)
			origin_seen <= 1'b0;
		else
			origin_seen <= motion.origin_set;
	end

	// Origin latch: set as the origin becomes set, wherever the motor
	// stands, cleared on the first move; setting wins over moving
	always_ff @(posedge clk) begin
		if (!resetn || !motion.origin_set)
			home_latched <= 1'b0;
		else if (!origin_seen)
			home_latched <= 1'b1;
		else if (moving_output)
			home_latched <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			home_output         <= 1'b0;
			complete_output     <= 1'b0;
			torque_limit_output <= 1'b0;
			zone_one_output     <= 1'b0;
			zone_two_output     <= 1'b0;
			zone_three_output   <= 1'b0;
		end else begin
			if (home_mode)
				home_output <= home_latched;
			else
				home_output <= motion.origin_set && !moving_output
					&& motion.cmd_pos == 24'sh000000;
			complete_output <= !moving_output
				&& settle_err <= 24'(end_range);
			torque_limit_output <= motion.torque_over;
			zone_one_output <= in_zone(motion.cmd_pos, zone_pos[0],
				zone_neg[0]);
			zone_two_output <= in_zone(motion.cmd_pos, zone_pos[1],
				zone_neg[1]);
			zone_three_output <= in_zone(motion.act_pos, zone_pos[2],
				zone_neg[2]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	ready_idle_a: assert property (@(posedge clk) disable iff (!resetn)
		ready_output |-> $past(!moving_output && !rdy_in.alarm))
		else $error("ready while moving or alarmed");
	warn_speed_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && meas.speed > speed_lim) |-> warning_output)
		else $error("overspeed not flagged");
	warn_temp_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && meas.temp >= temp_lim) |-> warning_output)
		else $error("overheat not flagged");
	home_orig_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && !home_mode && !motion.origin_set) |-> !home_output)
		else $error("home flag without origin");
	zone_equal_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && zone_pos[0] == zone_neg[0]
		&& motion.cmd_pos != zone_pos[0])
		|-> !zone_one_output)
		else $error("zone one on off exact point");
	zone_three_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && zone_pos[2] == zone_neg[2]
		&& motion.act_pos == zone_pos[2])
		|-> zone_three_output)
		else $error("zone three missed actual position");
	move_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		motion.operating |=> moving_output)
		else $error("moving flag not raised");
	done_stop_a: assert property (@(posedge clk) disable iff (!resetn)
		complete_output |-> $past(!moving_output))
		else $error("complete while moving");
	torque_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		motion.torque_over |=> torque_limit_output)
		else $error("torque flag missed");

	// Cycles the moving flag has stood so far, for the minimum-time check
	logic [31:0] mv_age;
	always_ff @(posedge clk) begin
		if (!resetn || !moving_output)
			mv_age <= 32'h00000000;
		else if (mv_age != 32'hFFFFFFFF)
			mv_age <= mv_age + 32'h00000001;
	end
	warn_over_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && meas.volt > over_v) |-> warning_output)
		else $error("overvoltage not flagged");
	warn_under_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && meas.volt < under_v) |-> warning_output)
		else $error("undervoltage not flagged");
	warn_dev_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && rdy_in.cur_on && meas.deviation > dev_lim)
		|-> warning_output)
		else $error("deviation not flagged");
	ready_block_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(!rdy_in.main_power || rdy_in.start_any || rdy_in.free_run
		|| rdy_in.stop || rdy_in.busy_tool) |-> !ready_output)
		else $error("ready while blocked");
	home_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		home_latched && motion.origin_set && !moving_output |=> home_latched)
		else $error("home latch lost while standing");
	zone_inv_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && zone_pos[0] < zone_neg[0] && (motion.cmd_pos
		<= zone_pos[0] || motion.cmd_pos >= zone_neg[0])) |-> zone_one_output)
		else $error("inverted zone one missed");
	zone_norm_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn && zone_pos[0] > zone_neg[0] && (motion.cmd_pos
		< zone_neg[0] || motion.cmd_pos > zone_pos[0])) |-> !zone_one_output)
		else $error("zone one on outside bounds");
	move_min_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(moving_output) |-> $past(mv_age) >= 32'(move_min) * 32'(MS_CYC))
		else $error("moving flag dropped early");
endmodule : mdso_status

/* File: dv/mdso_host.sv */
`timescale 1ns/10ps
// Host model: issues one-cycle motion commands, only once ready is seen
module mdso_host (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Status seen and request from the bench
	input  wire logic ready_output,
	input  wire logic go_req,
	output logic      go_cmd
);
	// One-cycle command; a held request never repeats it back to back
	always_ff @(posedge clk) begin
		if (!resetn) begin
			go_cmd <= 1'b0;
		end else begin
			go_cmd <= go_req && ready_output && !go_cmd;
		end
	end
endmodule : mdso_host

/* File: dv/mdso_status_test.sv */
`timescale 1ns/10ps
`define MDSO_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("Error at %0t: got %h want %h", $time, g, e); \
	end end
module mdso_status_test;
	import mdso_pkg::*;
	logic                 clk, resetn, reg_wr, reg_rd, go_req, go_cmd;
	logic [7:0]           reg_addr;
	logic [31:0]          reg_wdata, reg_rdata, d;
	mdso_meas_t           meas;
	mdso_ready_in_t       rdy;
	mdso_motion_t         mot, mot_w;
	logic                 warn, rdy_o, home, mov, cmpl, trq, z1, z2, z3;
	int                   miscompares, total_checks, n;
	////////////////////////////////////////////////////////////////////
	always_comb begin
		mot_w = mot;
		mot_w.operating = mot.operating | go_cmd;
	end
	mdso_status #(.DC_INPUT(1'b0), .MS_CYC(10), .TENTH_S_CYC(20)) dut_u (
		.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas(meas), .rdy_in(rdy), .motion(mot_w),
		.warning_output(warn), .ready_output(rdy_o), .home_output(home),
		.moving_output(mov), .complete_output(cmpl),
		.torque_limit_output(trq), .zone_one_output(z1),
		.zone_two_output(z2), .zone_three_output(z3));
	mdso_host host_u (.clk(clk), .resetn(resetn), .ready_output(rdy_o),
		.go_req(go_req), .go_cmd(go_cmd));
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog: whole run is about 250 cycles
	initial begin
		#100us;
		miscompares++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic warn_case(input logic [15:0] t, s, v, dv, input logic e);
		@(posedge clk);
		meas <= '{temp:t, speed:s, volt:v, deviation:dv, overload:1'b0};
		settle();
		`MDSO_CHK(warn, e)
	endtask : warn_case
	task automatic zone_case(input logic [23:0] p, q, c, input logic e);
		wr(8'h10, {8'h00, p});
		wr(8'h11, {8'h00, q});
		@(posedge clk);
		mot.cmd_pos <= c;
		settle();
		`MDSO_CHK(z1, e)
	endtask : zone_case
	////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		logic [7:0]  ad[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
			8'h06, 8'h08, 8'h20};
		logic [31:0] ex[9] = '{32'h55, 32'h32, 32'h1194, 32'h1B3, 32'h78,
			32'h12C, 32'h0, 32'h12, 32'h0};
		for (int i = 0; i < 9; i++) begin
			rd(ad[i]);
			`MDSO_CHK(d, ex[i])
		end
		$display("defaults done");
	endtask : t_defaults
	task automatic t_warning;
		warn_case(16'd85, 16'd100, 16'd300, 16'd0, 1'b1);
		warn_case(16'd84, 16'd100, 16'd300, 16'd0, 1'b0);
		warn_case(16'd20, 16'd4501, 16'd300, 16'd0, 1'b1);
		warn_case(16'd20, 16'd4500, 16'd300, 16'd0, 1'b0);
		warn_case(16'd20, 16'd100, 16'd436, 16'd0, 1'b1);
		warn_case(16'd20, 16'd100, 16'd119, 16'd0, 1'b1);
		warn_case(16'd20, 16'd100, 16'd120, 16'd301, 1'b1);
		warn_case(16'd20, 16'd100, 16'd435, 16'd300, 1'b0);
		wr(8'h01, 32'd1);
		meas.overload <= 1'b1;
		repeat (15) @(posedge clk);
		#1;
		`MDSO_CHK(warn, 1'b0)
		repeat (10) @(posedge clk);
		#1;
		`MDSO_CHK(warn, 1'b1)
		@(posedge clk);
		meas.overload <= 1'b0;
		$display("warning done");
	endtask : t_warning
	task automatic t_ready;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rdy <= 8'h8C ^ (8'h80 >> i);
			settle();
			`MDSO_CHK(rdy_o, (i == 4))
		end
		@(posedge clk);
		rdy <= 8'h8C;
		$display("ready done");
	endtask : t_ready
	task automatic t_moving;
		wr(8'h07, 32'd2);
		settle();
		@(posedge clk);
		go_req <= 1'b1;
		for (int i = 0; i < 20 && go_cmd !== 1'b1; i++) @(posedge clk);
		go_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`MDSO_CHK(mov, 1'b1)
		`MDSO_CHK(rdy_o, 1'b0)
		n = 0;
		repeat (40) begin
			@(posedge clk);
			#1 n += (mov === 1'b1);
		end
		`MDSO_CHK(n >= 17 && n <= 21, 1'b1)
		$display("moving done");
	endtask : t_moving
	task automatic t_home_end;
		@(posedge clk);
		mot <= '{cmd_pos:24'd0, act_pos:24'd18, origin_set:1'b1,
			operating:1'b0, torque_over:1'b1};
		settle();
		`MDSO_CHK(home, 1'b1)
		`MDSO_CHK(cmpl, 1'b1)
		`MDSO_CHK(trq, 1'b1)
		@(posedge clk);
		mot.act_pos <= 24'd19;
		mot.origin_set <= 1'b0;
		settle();
		`MDSO_CHK(home, 1'b0)
		`MDSO_CHK(cmpl, 1'b0)
		wr(8'h09, 32'd5);
		mot.act_pos <= 24'd23;
		settle();
		`MDSO_CHK(cmpl, 1'b1)
		wr(8'h06, 32'd1);
		rd(8'h06);
		`MDSO_CHK(d, 32'h1)
		@(posedge clk);
		mot.origin_set <= 1'b1;
		settle();
		@(posedge clk);
		mot.cmd_pos <= 24'd3;
		settle();
		`MDSO_CHK(home, 1'b1)
		@(posedge clk);
		mot.operating <= 1'b1;
		settle();
		`MDSO_CHK(home, 1'b0)
		@(posedge clk);
		mot.operating <= 1'b0;
		$display("home and end done");
	endtask : t_home_end
	task automatic t_zones;
		zone_case(24'd10, -24'sd10, 24'd0, 1'b1);
		zone_case(24'd10, -24'sd10, 24'd11, 1'b0);
		zone_case(-24'sd10, 24'd10, 24'd0, 1'b0);
		zone_case(-24'sd10, 24'd10, 24'd10, 1'b1);
		zone_case(24'd5, 24'd5, 24'd5, 1'b1);
		zone_case(24'd5, 24'd5, 24'd4, 1'b0);
		@(posedge clk);
		mot.act_pos <= 24'd0;
		mot.torque_over <= 1'b0;
		settle();
		`MDSO_CHK({z2, z3}, 2'b01)
		`MDSO_CHK(trq, 1'b0)
		rd(8'h0A);
		`MDSO_CHK(d, 32'h112)
		$display("zones done");
	endtask : t_zones
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, reg_wr, reg_rd, go_req, reg_addr, reg_wdata} = '0;
		meas = '{temp:16'd20, speed:16'd100, volt:16'd300, deviation:16'd0,
			overload:1'b0};
		rdy = 8'h8C;
		mot = '0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_defaults();
		t_warning();
		t_ready();
		t_moving();
		t_home_end();
		t_zones();
		test_done();
	end
endmodule : mdso_status_test
